// ### rtl/eie_exec.sv
// Escaped instruction decode and execute unit with forty-bit total register
`timescale 1ns/10ps
`default_nettype none
// Function
// - Byte A5 is an escape prefix; second byte picks the extended operation.
// - Arithmetic right shift keeps bit 39, two cycles, no flags.
// - Breakpoint with debug enabled calls debug handler, PC at next instruction.
// - Breakpoint with debug disabled is a two-cycle no-op, PC plus two.
// - Compare branch sets carry when accumulator below indirect byte, operands kept.
// - Compare branch adds three, then signed displacement only when unequal.
// - Clear opcode zeros all forty total bits in two cycles.
// - Alternate pointer increments modulo 65536, three cycles, no flags.
// - Indirect jump loads PC with accumulator plus PC plus two.
// - Stack opcodes take extra cycles with extended stack in use.
// - Pointer moves take 2/4 cycles, alternate pointer forms 3/5.
module eie_exec
  import eie_pkg::*;
(
  input wire logic clk_sys_in, // Core clock, 200 MHz
  input wire logic srst_in, // Synchronous reset, high
  input wire logic instr_valid_in, // Instruction bytes present
  input wire eie_instr_t instr_in, // Prefix, opcode, displacement
  input wire eie_core_t core_in, // PC, accumulator, RAM byte, pointers
  input wire eie_env_t env_in, // Debug, stack and memory space levels
  input wire logic total_load_in, // Multiplier writes the total register while idle, unless an instruction is taken in that cycle
  input wire logic [39:0] total_value_in, // Value for that write
  output logic busy_out, // Instruction in progress
  output logic done_out, // Final cycle, effects valid
  output logic escaped_out, // Last taken instruction was escaped
  output logic known_out, // Last taken opcode is handled here
  output logic pc_load_out, // Load PC from pc_next_out
  output logic [15:0] pc_next_out, // New program counter
  output logic carry_we_out, // Write carry flag
  output logic carry_out, // Carry value
  output logic ptr_we_out, // Write a data pointer
  output logic ptr_one_sel_out, // 1: data_pointer_one, 0: zero
  output logic [15:0] ptr_value_out, // New pointer value
  output logic debug_req_out, // Hand control to debug_handler
  output logic [39:0] total_out // Forty-bit total register
);
  eie_state_t state_q, state_d;
  logic busy_q, busy_d;
  logic timer_last;
  logic take;
  // Decoded effects of the incoming instruction
  logic [2:0] cyc_c;
  logic esc_c, known_c, pcld_c, cwe_c, carry_c, pwe_c, psel_c, dbg_c;
  logic [15:0] pc_c, pval_c, alt_ptr;
  eie_tot_op_t top_c;
  // Captured effects, released at the final cycle
  logic esc_q, known_q, pcld_q, cwe_q, carry_q, pwe_q, psel_q, dbg_q;
  logic [15:0] pc_q, pval_q;
  eie_tot_op_t top_q;
  // Output registers
  logic done_q, done_d, pcld_oq, cwe_oq, pwe_oq, dbg_oq;
  logic pcld_od, cwe_od, pwe_od, dbg_od;
  logic [39:0] tot_q, tot_d;

  assign take = instr_valid_in && !busy_q;
  // The pointer the select bit does not choose
  assign alt_ptr = core_in.pointer_select_bit ? core_in.data_pointer_zero
                                              : core_in.data_pointer_one;

  eie_cycle_timer u_timer (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .load_in(take),
    .count_in(cyc_c),
    .last_out(timer_last)
  );

  // Decode of the offered instruction
  always_comb
  begin
    cyc_c = CYC_ONE;
    known_c = 1'b1;
    pcld_c = 1'b0;
    pc_c = core_in.pc;
    cwe_c = 1'b0;
    carry_c = 1'b0;
    pwe_c = 1'b0;
    psel_c = !core_in.pointer_select_bit;
    pval_c = alt_ptr + PTR_STEP;
    dbg_c = 1'b0;
    top_c = EIE_TOT_NONE;
    esc_c = (instr_in.prefix == ESC_PREFIX);
    if (esc_c)
    begin
      case (instr_in.opcode)
        OP_ARITH_SHIFT_RIGHT:
        begin
          cyc_c = CYC_TOTAL_OP;
          top_c = EIE_TOT_SHIFT;
        end
        OP_CLR_TOTAL:
        begin
          cyc_c = CYC_TOTAL_OP;
          top_c = EIE_TOT_CLEAR;
        end
        OP_BREAK:
        begin
          cyc_c = CYC_BREAK;
          pcld_c = 1'b1;
          pc_c = core_in.pc + PC_STEP_TWO;
          dbg_c = env_in.debug_enable;
        end
        OP_CMP_BR_R0, OP_CMP_BR_R1:
        begin
          cyc_c = CYC_CMP_BR;
          pcld_c = 1'b1;
          cwe_c = 1'b1;
          carry_c = (core_in.acc < core_in.ram_byte);
          pc_c = core_in.pc + PC_STEP_THREE;
          if (core_in.acc != core_in.ram_byte)
          begin
            pc_c = core_in.pc + PC_STEP_THREE + {{8{instr_in.rel[7]}}, instr_in.rel};
          end
        end
        OP_INC_ALT:
        begin
          cyc_c = CYC_INC_ALT;
          pwe_c = 1'b1;
        end
        OP_JMP_A_PC:
        begin
          cyc_c = CYC_JMP_A_PC;
          pcld_c = 1'b1;
          pc_c = core_in.pc + PC_STEP_TWO + {BYTE_ZERO, core_in.acc};
        end
        OP_MOVX_RD, OP_MOVX_WR:
        begin
          cyc_c = env_in.xmem_onchip ? CYC_MOVX_ALT_RAM : CYC_MOVX_ALT_FAR;
        end
        default:
        begin
          known_c = 1'b0;
        end
      endcase
    end
    else
    begin
      case (instr_in.opcode)
        OP_PUSH, OP_POP:
        begin
          cyc_c = env_in.ext_stack ? CYC_PUSH_POP_EXT : CYC_PUSH_POP;
        end
        OP_LCALL:
        begin
          cyc_c = env_in.ext_stack ? CYC_LCALL_EXT : CYC_LCALL;
        end
        OP_RET, OP_RETI:
        begin
          cyc_c = env_in.ext_stack ? CYC_RET_EXT : CYC_RET;
        end
        OP_MOVX_RD, OP_MOVX_WR:
        begin
          cyc_c = env_in.xmem_onchip ? CYC_MOVX_RAM : CYC_MOVX_FAR;
        end
        default:
        begin
          if (instr_in.opcode[4:0] == OP_ACALL_LOW)
          begin
            cyc_c = env_in.ext_stack ? CYC_ACALL_EXT : CYC_ACALL;
          end
          else
          begin
            known_c = 1'b0;
          end
        end
      endcase
    end
  end

  // Capture of decoded effects when an instruction is taken
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      esc_q <= 1'b0;
      known_q <= 1'b0;
      pcld_q <= 1'b0;
      pc_q <= PC_RESET;
      cwe_q <= 1'b0;
      carry_q <= 1'b0;
      pwe_q <= 1'b0;
      psel_q <= 1'b0;
      pval_q <= PC_RESET;
      dbg_q <= 1'b0;
      top_q <= EIE_TOT_NONE;
    end
    else if (take)
    begin
      esc_q <= esc_c;
      known_q <= known_c;
      pcld_q <= pcld_c;
      pc_q <= pc_c;
      cwe_q <= cwe_c;
      carry_q <= carry_c;
      pwe_q <= pwe_c;
      psel_q <= psel_c;
      pval_q <= pval_c;
      dbg_q <= dbg_c;
      top_q <= top_c;
    end
  end

  // Sequencing and release of effects on the final cycle
  always_comb
  begin
    state_d = state_q;
    busy_d = busy_q;
    done_d = 1'b0;
    pcld_od = 1'b0;
    cwe_od = 1'b0;
    pwe_od = 1'b0;
    dbg_od = 1'b0;
    tot_d = tot_q;
    case (state_q)
      EIE_ST_IDLE:
      begin
        busy_d = 1'b0;
        if (take)
        begin
          state_d = EIE_ST_RUN;
          busy_d = 1'b1;
        end
        else if (total_load_in)
        begin
          tot_d = total_value_in;
        end
      end
      EIE_ST_RUN:
      begin
        if (timer_last)
        begin
          state_d = EIE_ST_IDLE;
          busy_d = 1'b0;
          done_d = 1'b1;
          pcld_od = pcld_q;
          cwe_od = cwe_q;
          pwe_od = pwe_q;
          dbg_od = dbg_q;
          if (top_q == EIE_TOT_SHIFT)
          begin
            tot_d = {tot_q[TOTAL_MSB], tot_q[TOTAL_MSB:1]};
          end
          else if (top_q == EIE_TOT_CLEAR)
          begin
            tot_d = TOTAL_RESET;
          end
        end
      end
      default:
      begin
        state_d = EIE_ST_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  // State and output registers
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      state_q <= EIE_ST_IDLE;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      pcld_oq <= 1'b0;
      cwe_oq <= 1'b0;
      pwe_oq <= 1'b0;
      dbg_oq <= 1'b0;
      tot_q <= TOTAL_RESET;
    end
    else
    begin
      state_q <= state_d;
      busy_q <= busy_d;
      done_q <= done_d;
      pcld_oq <= pcld_od;
      cwe_oq <= cwe_od;
      pwe_oq <= pwe_od;
      dbg_oq <= dbg_od;
      tot_q <= tot_d;
    end
  end

  // Strobes, busy and the total come from output flops; other values from capture flops
  assign busy_out = busy_q;
  assign done_out = done_q;
  assign escaped_out = esc_q;
  assign known_out = known_q;
  assign pc_load_out = pcld_oq;
  assign pc_next_out = pc_q;
  assign carry_we_out = cwe_oq;
  assign carry_out = carry_q;
  assign ptr_we_out = pwe_oq;
  assign ptr_one_sel_out = psel_q;
  assign ptr_value_out = pval_q;
  assign debug_req_out = dbg_oq;
  assign total_out = tot_q;

  // Checks: an instruction taken in cycle 0 releases its effects at cycle N+1
  AST_ESC_SPLIT: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    take && instr_in.prefix != ESC_PREFIX && instr_in.opcode == OP_ARITH_SHIFT_RIGHT
    |=> !escaped_out && !known_out)
    else $error("unprefixed byte decoded as extension");
  // Done flop is seen one edge after the timer's last cycle, hence N+1
  AST_SHIFT_KEEPS_SIGN: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    take && esc_c && instr_in.opcode == OP_ARITH_SHIFT_RIGHT
    |-> ##3 done_out && !carry_we_out
        && total_out[38:0] == $past(total_out[39:1], 3)
        && total_out[39] == $past(total_out[39], 3))
    else $error("shift result or timing wrong");
  AST_BREAK_DEBUG: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    take && esc_c && instr_in.opcode == OP_BREAK && env_in.debug_enable
    |-> ##3 debug_req_out && pc_load_out && pc_next_out == $past(core_in.pc, 3) + PC_STEP_TWO)
    else $error("breakpoint hand-off wrong");
  AST_BREAK_NOP: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    take && esc_c && instr_in.opcode == OP_BREAK && !env_in.debug_enable
    |-> ##1 !done_out ##1 !done_out ##1 done_out && !debug_req_out && !carry_we_out
        && pc_next_out == $past(core_in.pc, 3) + PC_STEP_TWO)
    else $error("breakpoint no-op wrong");
  AST_CMP_CARRY: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    take && esc_c && (instr_in.opcode == OP_CMP_BR_R0 || instr_in.opcode == OP_CMP_BR_R1)
    |-> ##5 carry_we_out && carry_out == ($past(core_in.acc, 5) < $past(core_in.ram_byte, 5)))
    else $error("compare carry wrong");
  AST_CMP_EQUAL_FALLS: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    take && esc_c && instr_in.opcode == OP_CMP_BR_R0 && core_in.acc == core_in.ram_byte
    |-> ##5 pc_load_out && pc_next_out == $past(core_in.pc, 5) + PC_STEP_THREE)
    else $error("equal compare must fall through");
  AST_CLEAR_TOTAL: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    take && esc_c && instr_in.opcode == OP_CLR_TOTAL |-> ##3 done_out && total_out == TOTAL_RESET)
    else $error("total not cleared in two cycles");
  AST_ALT_INC: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    take && esc_c && instr_in.opcode == OP_INC_ALT
    |-> ##4 ptr_we_out && ptr_one_sel_out == !$past(core_in.pointer_select_bit, 4)
        && ptr_value_out == $past(alt_ptr, 4) + PTR_STEP)
    else $error("alternate pointer increment wrong");
  AST_JMP_A_PC: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    take && esc_c && instr_in.opcode == OP_JMP_A_PC
    |-> ##4 pc_load_out && !carry_we_out
        && pc_next_out == $past(core_in.pc, 4) + PC_STEP_TWO + {8'h00, $past(core_in.acc, 4)})
    else $error("indirect jump target wrong");
  AST_POP_EXT: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    take && !esc_c && instr_in.opcode == OP_POP && env_in.ext_stack
    |=> !done_out [*3] ##1 done_out)
    else $error("extended stack pop not three cycles");
  AST_MOVX_ALT_FAR: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    take && esc_c && instr_in.opcode == OP_MOVX_RD && !env_in.xmem_onchip
    |=> !done_out [*5] ##1 done_out)
    else $error("alternate far move not five cycles");
  COV_BREAK_DEBUG: cover property (@(posedge clk_sys_in) disable iff (srst_in)
    debug_req_out);
  COV_CMP_TAKEN: cover property (@(posedge clk_sys_in) disable iff (srst_in)
    take && esc_c && instr_in.opcode == OP_CMP_BR_R1 && core_in.acc != core_in.ram_byte);
  COV_BACK_TO_BACK: cover property (@(posedge clk_sys_in) disable iff (srst_in)
    done_out && take);
endmodule // eie_exec
`default_nettype wire

// ### shared/eie_pkg.sv
// Package for the escaped instruction execution block: opcodes, cycle counts, types
package eie_pkg;
  // Escape prefix and second opcode bytes
  localparam logic [7:0] ESC_PREFIX = 8'hA5;
  localparam logic [7:0] OP_BREAK = 8'h00;
  localparam logic [7:0] OP_ARITH_SHIFT_RIGHT = 8'h03;
  localparam logic [7:0] OP_CLR_TOTAL = 8'hE4;
  localparam logic [7:0] OP_INC_ALT = 8'hA3;
  localparam logic [7:0] OP_JMP_A_PC = 8'h73;
  localparam logic [7:0] OP_CMP_BR_R0 = 8'hB6;
  localparam logic [7:0] OP_CMP_BR_R1 = 8'hB7;
  localparam logic [7:0] OP_MOVX_RD = 8'hE0;
  localparam logic [7:0] OP_MOVX_WR = 8'hF0;
  // Unescaped stack opcodes
  localparam logic [7:0] OP_PUSH = 8'hC0;
  localparam logic [7:0] OP_POP = 8'hD0;
  localparam logic [7:0] OP_LCALL = 8'h12;
  localparam logic [7:0] OP_RET = 8'h22;
  localparam logic [7:0] OP_RETI = 8'h32;
  localparam logic [4:0] OP_ACALL_LOW = 5'h11;
  // Cycle counts
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TOTAL_OP = 3'h2;
  localparam logic [2:0] CYC_BREAK = 3'h2;
  localparam logic [2:0] CYC_CMP_BR = 3'h4;
  localparam logic [2:0] CYC_INC_ALT = 3'h3;
  localparam logic [2:0] CYC_JMP_A_PC = 3'h3;
  localparam logic [2:0] CYC_PUSH_POP = 3'h2;
  localparam logic [2:0] CYC_PUSH_POP_EXT = 3'h3;
  localparam logic [2:0] CYC_ACALL = 3'h3;
  localparam logic [2:0] CYC_ACALL_EXT = 3'h5;
  localparam logic [2:0] CYC_LCALL = 3'h4;
  localparam logic [2:0] CYC_LCALL_EXT = 3'h6;
  localparam logic [2:0] CYC_RET = 3'h4;
  localparam logic [2:0] CYC_RET_EXT = 3'h5;
  localparam logic [2:0] CYC_MOVX_RAM = 3'h2;
  localparam logic [2:0] CYC_MOVX_FAR = 3'h4;
  localparam logic [2:0] CYC_MOVX_ALT_RAM = 3'h3;
  localparam logic [2:0] CYC_MOVX_ALT_FAR = 3'h5;
  // Program counter steps and widths
  localparam logic [15:0] PC_STEP_TWO = 16'h0002;
  localparam logic [15:0] PC_STEP_THREE = 16'h0003;
  localparam logic [15:0] PTR_STEP = 16'h0001;
  localparam int TOTAL_W = 40;
  localparam int TOTAL_MSB = 39;
  localparam logic [39:0] TOTAL_RESET = 40'h00_0000_0000;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Operations on the forty-bit total register
  typedef enum logic [1:0] {
    EIE_TOT_NONE = 2'b00,
    EIE_TOT_SHIFT = 2'b01,
    EIE_TOT_CLEAR = 2'b11
  } eie_tot_op_t;

  // Control states, Gray along idle to run
  typedef enum logic [1:0] {
    EIE_ST_IDLE = 2'b00,
    EIE_ST_RUN = 2'b01
  } eie_state_t;

  // Instruction bytes handed over by the fetch unit
  typedef struct packed {
    logic [7:0] prefix;
    logic [7:0] opcode;
    logic [7:0] rel;
  } eie_instr_t;

  // Core state sampled when an instruction is taken
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] acc;
    logic [7:0] ram_byte;
    logic pointer_select_bit;
    logic [15:0] data_pointer_zero;
    logic [15:0] data_pointer_one;
  } eie_core_t;

  // Environment levels
  typedef struct packed {
    logic debug_enable;
    logic ext_stack;
    logic xmem_onchip;
  } eie_env_t;
endpackage : eie_pkg

// ### rtl/eie_cycle_timer.sv
// Down counter that stretches an instruction over its cycle count
`timescale 1ns/10ps
`default_nettype none
module eie_cycle_timer
  import eie_pkg::*;
(
  input wire logic clk_sys_in, // Core clock
  input wire logic srst_in, // Synchronous reset, high
  input wire logic load_in, // Start a new count
  input wire logic [2:0] count_in, // Cycles to run
  output logic last_out // Final cycle of the count
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;

  // Next count: load wins, otherwise step down to zero
  always_comb
  begin
    cnt_d = cnt_q;
    if (load_in)
    begin
      cnt_d = count_in;
    end
    else if (cnt_q != 3'h0)
    begin
      cnt_d = cnt_q - 3'h1;
    end
  end

  // Count register
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      cnt_q <= 3'h0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  assign last_out = (cnt_q == 3'h1);
endmodule // eie_cycle_timer
`default_nettype wire

// ### testbench/tb_escaped_instruction_exec.sv
// Self-checking bench for the escaped instruction execution unit
`timescale 1ns/10ps
`default_nettype none
module tb_escaped_instruction_exec
  import eie_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic instr_valid_in = 1'b0;
  eie_instr_t instr_in = '0;
  eie_core_t core_in = '0;
  eie_env_t env_in = '0;
  logic total_load_in = 1'b0;
  logic [39:0] total_value_in = '0;
  logic busy_out, done_out, escaped_out, known_out, pc_load_out;
  logic [15:0] pc_next_out;
  logic carry_we_out, carry_out, ptr_we_out, ptr_one_sel_out;
  logic [15:0] ptr_value_out;
  logic debug_req_out;
  logic [39:0] total_out;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;

  eie_exec eie_exec_inst (
    .clk_sys_in, .srst_in, .instr_valid_in, .instr_in, .core_in, .env_in,
    .total_load_in, .total_value_in, .busy_out, .done_out, .escaped_out,
    .known_out, .pc_load_out, .pc_next_out, .carry_we_out, .carry_out,
    .ptr_we_out, .ptr_one_sel_out, .ptr_value_out, .debug_req_out, .total_out
  );

  // Core clock, 5 ns period
  always #2.5 clk_sys_in = ~clk_sys_in;

  // Verdict and end of run
  task automatic end_of_test();
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  // Compare and count
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic eie_core_t mk(logic [15:0] pc, logic [7:0] acc, logic [7:0] ram,
                                   logic psb, logic [15:0] p0, logic [15:0] p1);
    return eie_core_t'{pc, acc, ram, psb, p0, p1};
  endfunction

  // Offer one instruction, count edges from the take to done
  task automatic run(input logic [7:0] pre, input logic [7:0] op, input logic [7:0] rel,
                     input eie_core_t c, input eie_env_t e, output int n);
    @(posedge clk_sys_in);
    instr_valid_in <= 1'b1;
    instr_in <= eie_instr_t'{pre, op, rel};
    core_in <= c;
    env_in <= e;
    @(posedge clk_sys_in);
    instr_valid_in <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_sys_in);
      n++;
      #1;
    end
    while (done_out !== 1'b1 && n < 10);
  endtask

  // Outside write of the total register while idle
  task automatic load_total(input logic [39:0] v);
    @(posedge clk_sys_in);
    total_load_in <= 1'b1;
    total_value_in <= v;
    @(posedge clk_sys_in);
    total_load_in <= 1'b0;
    @(posedge clk_sys_in);
    #1;
  endtask

  // Sign kept on shift; bare byte is not an extension
  task automatic t_shift();
    int n;
    load_total(40'hC5B1A29384);
    run(ESC_PREFIX, OP_ARITH_SHIFT_RIGHT, 8'h00, mk(16'h0100, 8'h00, 8'h00, 1'b0, 16'h0, 16'h0), '0, n);
    chk(40'(n), 40'h2);
    chk(total_out, 40'hE2D8D149C2);
    chk({37'h0, known_out, carry_we_out, escaped_out}, 40'h5);
    load_total(40'h4500000001);
    run(ESC_PREFIX, OP_ARITH_SHIFT_RIGHT, 8'h00, mk(16'h0100, 8'h00, 8'h00, 1'b0, 16'h0, 16'h0), '0, n);
    chk(total_out, 40'h2280000000);
    run(8'h00, OP_ARITH_SHIFT_RIGHT, 8'h00, mk(16'h0100, 8'h00, 8'h00, 1'b0, 16'h0, 16'h0), '0, n);
    chk(40'(n), 40'h1);
    chk({total_out[38:0], escaped_out}, {39'h2280000000, 1'b0});
    chk({39'h0, known_out}, 40'h0);
  endtask

  // Clear zeroes all forty bits, strobe lasts one cycle
  task automatic t_clear();
    int n;
    load_total(40'hFF3456789A);
    run(ESC_PREFIX, OP_CLR_TOTAL, 8'h00, mk(16'h0100, 8'h00, 8'h00, 1'b0, 16'h0, 16'h0), '0, n);
    chk(40'(n), 40'h2);
    chk(total_out, 40'h0);
    chk({39'h0, carry_we_out}, 40'h0);
    @(posedge clk_sys_in);
    #1;
    chk({38'h0, done_out, busy_out}, 40'h0);
  endtask

  // Breakpoint with debug on and off
  task automatic t_break();
    int n;
    for (int d = 0; d < 2; d++)
    begin
      run(ESC_PREFIX, OP_BREAK, 8'h00, mk(16'h1234, 8'h00, 8'h00, 1'b0, 16'h0, 16'h0),
          eie_env_t'{d[0], 1'b0, 1'b0}, n);
      chk(40'(n), 40'h2);
      chk({37'h0, pc_load_out, debug_req_out, carry_we_out}, {37'h0, 1'b1, d[0], 1'b0});
      chk({24'h0, pc_next_out}, 40'h1236);
    end
  endtask

  // Compare branch: less, greater, equal, wrap cases
  task automatic t_cmp();
    int n;
    logic [7:0] acc[5] = '{8'h34, 8'h80, 8'h56, 8'h00, 8'hFF};
    logic [7:0] ram[5] = '{8'h56, 8'h7F, 8'h56, 8'hFF, 8'h00};
    logic [7:0] rel[5] = '{8'h10, 8'hF0, 8'h10, 8'h80, 8'h7F};
    logic [15:0] pc[5] = '{16'h0200, 16'h0200, 16'h0200, 16'h0010, 16'hFFF0};
    logic [15:0] exp_pc;
    for (int i = 0; i < 5; i++)
    begin
      exp_pc = pc[i] + 16'h0003 + ((acc[i] != ram[i]) ? {{8{rel[i][7]}}, rel[i]} : 16'h0000);
      run(ESC_PREFIX, i[0] ? OP_CMP_BR_R1 : OP_CMP_BR_R0, rel[i],
          mk(pc[i], acc[i], ram[i], 1'b0, 16'h0, 16'h0), '0, n);
      chk(40'(n), 40'h4);
      chk({37'h0, carry_we_out, carry_out, ptr_we_out}, {37'h0, 1'b1, acc[i] < ram[i], 1'b0});
      chk({23'h0, pc_load_out, pc_next_out}, {23'h0, 1'b1, exp_pc});
    end
  endtask

  // Alternate pointer increment with low and full wrap
  task automatic t_inc_alt();
    int n;
    logic psb[3] = '{1'b0, 1'b0, 1'b1};
    logic [15:0] p0[3] = '{16'h1111, 16'h1111, 16'h12FF};
    logic [15:0] p1[3] = '{16'h12FE, 16'hFFFF, 16'h2222};
    logic [15:0] ev[3] = '{16'h12FF, 16'h0000, 16'h1300};
    for (int i = 0; i < 3; i++)
    begin
      run(ESC_PREFIX, OP_INC_ALT, 8'h00, mk(16'h0100, 8'h00, 8'h00, psb[i], p0[i], p1[i]), '0, n);
      chk(40'(n), 40'h3);
      chk({21'h0, ptr_we_out, ptr_one_sel_out, carry_we_out, ptr_value_out},
          {21'h0, 1'b1, ~psb[i], 1'b0, ev[i]});
    end
  endtask

  // Indirect jump with and without wrap
  task automatic t_jmp();
    int n;
    run(ESC_PREFIX, OP_JMP_A_PC, 8'h00, mk(16'hFFF0, 8'hF0, 8'h00, 1'b0, 16'h0, 16'h0), '0, n);
    chk(40'(n), 40'h3);
    chk({22'h0, pc_load_out, carry_we_out, pc_next_out}, {22'h0, 2'b10, 16'h00E2});
    run(ESC_PREFIX, OP_JMP_A_PC, 8'h00, mk(16'h0100, 8'h04, 8'h00, 1'b0, 16'h0, 16'h0), '0, n);
    chk({24'h0, pc_next_out}, 40'h0106);
  endtask

  // Stack opcodes on normal and extended stack
  task automatic t_stack();
    int n;
    logic [7:0] op[6] = '{OP_PUSH, OP_POP, OP_LCALL, OP_RET, OP_RETI, 8'hF1};
    int base[6] = '{2, 2, 4, 4, 4, 3};
    int ext[6] = '{3, 3, 6, 5, 5, 5};
    for (int x = 0; x < 2; x++)
      for (int i = 0; i < 6; i++)
      begin
        run(8'h00, op[i], 8'h00, mk(16'h0100, 8'h00, 8'h00, 1'b0, 16'h0, 16'h0),
            eie_env_t'{1'b0, x[0], 1'b0}, n);
        chk(40'(n), x[0] ? 40'(ext[i]) : 40'(base[i]));
      end
  endtask

  // Pointer moves, plain and alternate, near and far
  task automatic t_movx();
    int n;
    int e;
    for (int k = 0; k < 8; k++)
    begin
      e = (k[2] ? 3 : 2) + (k[1] ? 0 : 2);
      run(k[2] ? ESC_PREFIX : 8'h00, k[0] ? OP_MOVX_WR : OP_MOVX_RD, 8'h00,
          mk(16'h0100, 8'h00, 8'h00, 1'b0, 16'h0, 16'h0), eie_env_t'{1'b0, 1'b0, k[1]}, n);
      chk(40'(n), 40'(e));
    end
  endtask

  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    @(posedge clk_sys_in);
    #1;
    chk({total_out[38:0], busy_out}, 40'h0);
    t_shift();
    t_clear();
    t_break();
    t_cmp();
    t_inc_alt();
    t_jmp();
    t_stack();
    t_movx();
    end_of_test();
  end
endmodule // tb_escaped_instruction_exec
`default_nettype wire
